// ### verilog/msa_pkg.sv
// Purpose: constants and types shared by the memory space access unit
// Assumes: 16-bit data space, byte addressed, 24-bit program addresses
// Notes: widths of the implemented area are parameters of the top module
package msa_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int PROG_ADDR_W = 24;
   localparam int PROG_WORD_W = 24;
   localparam logic [PROG_ADDR_W-1:0] RESET_VECTOR_ADDR = 24'h00_0000;
   localparam logic [PROG_ADDR_W-1:0] RESET_TARGET_ADDR = 24'h00_0002;
   localparam logic [PROG_ADDR_W-1:0] VECTOR_REGION_END = 24'h00_0200;
   localparam logic [PROG_ADDR_W-1:0] PRIMARY_TABLE_BASE = 24'h00_0004;
   localparam logic [PROG_ADDR_W-1:0] PRIMARY_TABLE_END = 24'h00_00FF;
   localparam logic [PROG_ADDR_W-1:0] ALTERNATE_TABLE_BASE = 24'h00_0100;
   localparam logic [PROG_ADDR_W-1:0] PC_STEP = 24'h00_0002;
   localparam logic [ADDR_W-1:0] SFR_LAST_ADDR = 16'h07FF;
   localparam logic [ADDR_W-1:0] NEAR_LAST_ADDR = 16'h1FFF;
   localparam logic [ADDR_W-1:0] DATA_RAM_BYTES_MAX = 16'h7800;
   localparam logic [ADDR_W-1:0] DEF_RAM_END = 16'h2800;
   localparam logic [ADDR_W-1:0] DEF_XY_BOUNDARY = 16'h1800;
   localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
   localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   localparam int WREG_COUNT = 16;
   localparam int NEAR_FIELD_W = 13;

   typedef enum logic [1:0] {
      MSA_ERR_NONE = 2'h0,
      MSA_ERR_READ = 2'h1,
      MSA_ERR_WRITE = 2'h2
   } msa_err_kind_t;

   typedef enum logic [1:0] {
      MSA_EXT_NONE = 2'h0,
      MSA_EXT_SIGN = 2'h1,
      MSA_EXT_ZERO = 2'h2
   } msa_ext_op_t;
endpackage : msa_pkg

// ### verilog/msa_lane_if.sv
// Purpose: byte-lane read port between the top and a lane reader
// Assumes: one word address decode shared by both lanes
// Notes: the reader answers combinationally
`timescale 1ns/100ps
interface msa_lane_if;
   logic [15:0] word;
   logic byte_sel;
   logic is_byte;
   logic [15:0] data;
   modport top (output word, output byte_sel, output is_byte, input data);
   modport unit (input word, input byte_sel, input is_byte, output data);
endinterface : msa_lane_if

// ### verilog/msa_lane_read.sv
// Purpose: picks the addressed byte of a fetched word onto the low lane
// Assumes: even byte address is the low byte of the word
// Notes: used for both the X and the Y read paths
`timescale 1ns/100ps
module msa_lane_read (
   msa_lane_if.unit lane
);
   always_comb begin
      if (lane.is_byte) begin
         lane.data = {8'h00, lane.byte_sel ? lane.word[15:8] : lane.word[7:0]};
      end else begin
         lane.data = lane.word;
      end
   end
endmodule : msa_lane_read

// ### verilog/msa_top.sv
// Purpose: data and program address mapping and access for the core
// Assumes: requests come from the core on clk; reads answer one cycle later
// Notes: Y space only reads; an X read of program space above the data window is a visibility request
`timescale 1ns/100ps
module msa_top #(
   parameter logic [15:0] RAM_END = msa_pkg::DEF_RAM_END,
   parameter logic [15:0] XY_BOUNDARY = msa_pkg::DEF_XY_BOUNDARY,
   parameter int RAM_WORDS = 2048
) (
   input wire logic clk,
   input wire logic rst_n,
   // program counter
   input wire logic pc_advance,
   input wire logic pc_backward,
   input wire logic pc_load,
   input wire logic [23:0] pc_load_addr,
   input wire logic vector_take,
   input wire logic vector_alt,
   input wire logic [6:0] vector_num,
   output logic [23:0] program_counter,
   output logic [23:0] prog_word,
   input wire logic [23:0] prog_fetch_word,
   // X space access
   input wire logic x_req,
   input wire logic x_write,
   input wire logic x_byte,
   input wire logic x_near,
   input wire logic [15:0] effective_address,
   input wire logic [15:0] x_wdata,
   input wire logic x_modulo,
   input wire logic x_bitrev,
   input wire logic [15:0] mod_start,
   input wire logic [15:0] mod_end,
   output logic [15:0] x_rdata,
   output logic x_rvalid,
   output logic [15:0] x_next_addr,
   output logic psv_req,
   output logic [14:0] psv_addr,
   // Y space read, multiply-accumulate class only
   input wire logic y_req,
   input wire logic multiply_accumulate_class,
   input wire logic [15:0] y_addr,
   input wire logic y_modulo,
   output logic [15:0] y_rdata,
   output logic y_rvalid,
   output logic [15:0] y_next_addr,
   // special register bus
   output logic sfr_wr_lo,
   output logic sfr_wr_hi,
   output logic [10:0] sfr_addr,
   output logic [15:0] sfr_wdata,
   input wire logic [15:0] sfr_rdata,
   input wire logic sfr_implemented,
   // working registers
   input wire logic wreg_we,
   input wire logic wreg_byte,
   input wire logic [3:0] wreg_sel,
   input wire logic [15:0] wreg_wdata,
   input wire logic [1:0] ext_op,
   output logic [15:0] wreg_rdata,
   // exception logic
   output logic addr_err_req,
   output logic [1:0] addr_err_kind
);
   localparam int RAM_AW = $clog2(RAM_WORDS);

   typedef struct packed {
      logic [23:0] pc;
      logic [23:0] pword;
      logic [15:0] x_rdata;
      logic x_rvalid;
      logic [15:0] x_next;
      logic psv_req;
      logic [14:0] psv_addr;
      logic [15:0] y_rdata;
      logic y_rvalid;
      logic [15:0] y_next;
      logic sfr_wr_lo;
      logic sfr_wr_hi;
      logic [10:0] sfr_addr;
      logic [15:0] sfr_wdata;
      logic [15:0] wreg_rd;
      logic err_req;
      logic [1:0] err_kind;
      logic [RAM_WORDS*16-1:0] ram;
      logic [16*16-1:0] wregs;
   } msa_state_t;

   msa_state_t s_q;
   msa_state_t s_d;
   msa_lane_if xl ();
   msa_lane_if yl ();
   logic [15:0] x_ea;
   logic [15:0] x_fetch;
   logic [15:0] y_fetch;
   logic x_odd_word;
   logic x_in_ram;
   logic x_in_sfr;
   logic y_in_ram;

   msa_lane_read u_x_lane (.lane(xl.unit));
   msa_lane_read u_y_lane (.lane(yl.unit));

   function automatic logic [15:0] bitrev_next(input logic [15:0] a, input logic [15:0] mod_len);
      logic [15:0] r;
      r = a ^ mod_len;
      return r;
   endfunction : bitrev_next

   function automatic logic [15:0] step_mod(input logic [15:0] a, input logic [15:0] step, input logic en,
                                            input logic [15:0] lo, input logic [15:0] hi);
      logic [15:0] n;
      n = a + step;
      if (en && (n > hi)) begin
         n = lo;
      end
      return n;
   endfunction : step_mod

   always_comb begin
      // near-field access keeps only 13 bits of the address
      x_ea = x_near ? {3'b000, effective_address[msa_pkg::NEAR_FIELD_W-1:0]} : effective_address;
      x_odd_word = x_req && !x_byte && effective_address[0];
      x_in_sfr = !x_ea[15] && (x_ea <= msa_pkg::SFR_LAST_ADDR);
      x_in_ram = !x_ea[15] && !x_in_sfr && (x_ea < RAM_END) && (x_ea < msa_pkg::DATA_RAM_BYTES_MAX);
      y_in_ram = (y_addr >= XY_BOUNDARY) && (y_addr < RAM_END) && !y_addr[15];
      x_fetch = msa_pkg::ZERO_WORD;
      if (x_in_sfr) begin
         x_fetch = sfr_implemented ? sfr_rdata : msa_pkg::ZERO_WORD;
      end else if (x_in_ram) begin
         x_fetch = s_q.ram[16*x_ea[RAM_AW:1] +: 16];
      end
      y_fetch = y_in_ram ? s_q.ram[16*y_addr[RAM_AW:1] +: 16] : msa_pkg::ZERO_WORD;
   end

   assign xl.word = x_fetch;
   assign xl.byte_sel = x_ea[0];
   assign xl.is_byte = x_byte;
   assign yl.word = y_fetch;
   assign yl.byte_sel = 1'b0;
   assign yl.is_byte = 1'b0;

   always_comb begin
      logic [15:0] w;
      logic [15:0] stp;
      w = '0;
      stp = '0;
      s_d = s_q;
      s_d.x_rvalid = 1'b0;
      s_d.y_rvalid = 1'b0;
      s_d.psv_req = 1'b0;
      s_d.sfr_wr_lo = 1'b0;
      s_d.sfr_wr_hi = 1'b0;
      s_d.err_req = 1'b0;
      s_d.err_kind = msa_pkg::MSA_ERR_NONE;
      // program counter
      if (vector_take) begin
         s_d.pc = (vector_alt ? msa_pkg::ALTERNATE_TABLE_BASE : msa_pkg::PRIMARY_TABLE_BASE)
                  + {16'h0000, vector_num, 1'b0};
      end else if (pc_load) begin
         s_d.pc = {pc_load_addr[23:1], 1'b0};
      end else if (pc_advance) begin
         s_d.pc = pc_backward ? s_q.pc - msa_pkg::PC_STEP : s_q.pc + msa_pkg::PC_STEP;
      end
      s_d.pword = {8'h00, prog_fetch_word[15:0]} | {prog_fetch_word[23:16], 16'h0000};
      // X access
      stp = x_byte ? msa_pkg::STEP_BYTE : msa_pkg::STEP_WORD;
      if (x_req) begin
         if (x_write && x_bitrev) begin
            s_d.x_next = bitrev_next(effective_address, mod_end);
         end else begin
            s_d.x_next = step_mod(effective_address, stp, x_modulo, mod_start, mod_end);
         end
         if (x_odd_word) begin
            s_d.err_req = 1'b1;
            s_d.err_kind = x_write ? msa_pkg::MSA_ERR_WRITE : msa_pkg::MSA_ERR_READ;
         end
         if (!x_write) begin
            s_d.x_rvalid = 1'b1;
            s_d.x_rdata = xl.data;
            s_d.psv_req = x_ea[15];
            s_d.psv_addr = x_ea[14:0];
         end else if (!x_odd_word) begin
            w = x_byte ? {x_wdata[7:0], x_wdata[7:0]} : x_wdata;
            if (x_in_sfr) begin
               s_d.sfr_wr_lo = !x_byte || !x_ea[0];
               s_d.sfr_wr_hi = !x_byte || x_ea[0];
               s_d.sfr_addr = x_ea[10:0];
               s_d.sfr_wdata = w;
            end else if (x_in_ram) begin
               if (!x_byte || !x_ea[0]) begin
                  s_d.ram[16*x_ea[RAM_AW:1] +: 8] = w[7:0];
               end
               if (!x_byte || x_ea[0]) begin
                  s_d.ram[16*x_ea[RAM_AW:1] + 8 +: 8] = w[15:8];
               end
            end
         end
      end
      // Y read path, second operand only
      if (y_req && multiply_accumulate_class) begin
         s_d.y_rvalid = 1'b1;
         s_d.y_rdata = yl.data;
         s_d.y_next = step_mod(y_addr, msa_pkg::STEP_WORD, y_modulo, mod_start, mod_end);
      end
      // working registers
      if (wreg_we) begin
         w = s_q.wregs[16*wreg_sel +: 16];
         unique case (msa_pkg::msa_ext_op_t'(ext_op))
            msa_pkg::MSA_EXT_SIGN: w = {{8{w[7]}}, w[7:0]};
            msa_pkg::MSA_EXT_ZERO: w = {8'h00, w[7:0]};
            default: w = wreg_byte ? {w[15:8], wreg_wdata[7:0]} : wreg_wdata;
         endcase
         s_d.wregs[16*wreg_sel +: 16] = w;
      end
      s_d.wreg_rd = s_d.wregs[16*wreg_sel +: 16];
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.pc <= msa_pkg::RESET_VECTOR_ADDR;
      end else begin
         s_q <= s_d;
      end
   end

   assign program_counter = s_q.pc;
   assign prog_word = s_q.pword;
   assign x_rdata = s_q.x_rdata;
   assign x_rvalid = s_q.x_rvalid;
   assign x_next_addr = s_q.x_next;
   assign psv_req = s_q.psv_req;
   assign psv_addr = s_q.psv_addr;
   assign y_rdata = s_q.y_rdata;
   assign y_rvalid = s_q.y_rvalid;
   assign y_next_addr = s_q.y_next;
   assign sfr_wr_lo = s_q.sfr_wr_lo;
   assign sfr_wr_hi = s_q.sfr_wr_hi;
   assign sfr_addr = s_q.sfr_addr;
   assign sfr_wdata = s_q.sfr_wdata;
   assign wreg_rdata = s_q.wreg_rd;
   assign addr_err_req = s_q.err_req;
   assign addr_err_kind = s_q.err_kind;

   a_pc_even: assert property (@(posedge clk) disable iff (!rst_n) program_counter[0] == 1'b0)
      else $error("program counter odd");
   a_pc_step: assert property (@(posedge clk) disable iff (!rst_n)
      pc_advance && !pc_load && !vector_take && !pc_backward
      |=> program_counter == $past(program_counter) + msa_pkg::PC_STEP)
      else $error("pc step wrong");
   a_reset_pc: assert property (@(posedge clk) $rose(rst_n) |-> program_counter == 24'h00_0000)
      else $error("pc not zero after reset");
   a_err_pulse: assert property (@(posedge clk) disable iff (!rst_n) addr_err_req |=> !addr_err_req || $past(x_odd_word))
      else $error("error request stretched");
   a_odd_word_err: assert property (@(posedge clk) disable iff (!rst_n)
      x_req && !x_byte && effective_address[0] |=> addr_err_req && addr_err_kind != 2'h0)
      else $error("misaligned word not flagged");
   a_write_suppress: assert property (@(posedge clk) disable iff (!rst_n)
      x_req && x_write && x_odd_word |=> !sfr_wr_lo && !sfr_wr_hi)
      else $error("misaligned write not suppressed");
   a_byte_lane: assert property (@(posedge clk) disable iff (!rst_n) !(sfr_wr_lo && sfr_wr_hi) || !$past(x_byte))
      else $error("byte write hit both lanes");
   a_psv_route: assert property (@(posedge clk) disable iff (!rst_n)
      x_req && !x_write && !x_near && effective_address[15] |=> psv_req && x_rdata == 16'h0000)
      else $error("upper half not routed");
   a_byte_low: assert property (@(posedge clk) disable iff (!rst_n)
      x_req && !x_write && x_byte |=> x_rdata[15:8] == 8'h00)
      else $error("byte read high lane set");
   a_y_mac_only: assert property (@(posedge clk) disable iff (!rst_n) y_rvalid |-> $past(multiply_accumulate_class))
      else $error("y read without mac class");
   a_post_inc: assert property (@(posedge clk) disable iff (!rst_n)
      x_req && !x_modulo && !(x_write && x_bitrev)
      |=> x_next_addr == $past(effective_address) + ($past(x_byte) ? msa_pkg::STEP_BYTE : msa_pkg::STEP_WORD))
      else $error("post increment wrong");
   c_misaligned_read: cover property (@(posedge clk) addr_err_req && addr_err_kind == 2'h1);
   c_misaligned_write: cover property (@(posedge clk) addr_err_req && addr_err_kind == 2'h2);
   c_dual_fetch: cover property (@(posedge clk) x_rvalid && y_rvalid);
   c_vector: cover property (@(posedge clk) vector_take && vector_alt);
endmodule : msa_top

// ### verification/msa_sfr_model.sv
// Purpose: special register space answering the access unit
// Assumes: bytes below IMPL are implemented registers, the rest unused
// Notes: unused places show a pattern that changes each cycle, so a unit that fails to zero them is caught
`timescale 1ns/100ps
module msa_sfr_model #(
   parameter logic [15:0] IMPL = 16'h0040
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] effective_address,
   input wire logic sfr_wr_lo,
   input wire logic sfr_wr_hi,
   input wire logic [10:0] sfr_addr,
   input wire logic [15:0] sfr_wdata,
   output logic [15:0] sfr_rdata,
   output logic sfr_implemented
);
   logic [15:0] regs_q [32];
   logic [15:0] junk_q;
   logic hit;
   assign sfr_implemented = effective_address < IMPL;
   assign sfr_rdata = sfr_implemented ? regs_q[effective_address[5:1]] : junk_q;
   assign hit = {5'h0, sfr_addr} < IMPL;
   always_ff @(posedge clk) begin
      junk_q <= {junk_q[14:0], ~junk_q[15]};
      if (!rst_n) begin
         junk_q <= 16'h5a5a;
         for (int i = 0; i < 32; i++) regs_q[i] <= 16'h0000;
      end else begin
         if (sfr_wr_lo && hit) regs_q[sfr_addr[5:1]][7:0] <= sfr_wdata[7:0];
         if (sfr_wr_hi && hit) regs_q[sfr_addr[5:1]][15:8] <= sfr_wdata[15:8];
      end
   end
endmodule : msa_sfr_model

// ### verification/memory_space_access_unit_test.sv
// Purpose: self-checking bench for the memory space access unit
// Assumes: every answer arrives one cycle after the request edge
// Notes: byte writes carry noise in the high byte of the write data; only the low byte may land
`timescale 1ns/100ps
module memory_space_access_unit_test;
   localparam logic [15:0] RAM_END_T = 16'h1000;
   localparam logic [15:0] IMPL = 16'h0040;
   logic clk, rst_n, pc_advance, pc_backward, pc_load, vector_take, vector_alt;
   logic [23:0] pc_load_addr, program_counter, prog_word, prog_fetch_word, pc;
   logic [6:0] vector_num;
   logic x_req, x_write, x_byte, x_near, x_modulo, x_bitrev, x_rvalid, psv_req;
   logic [15:0] effective_address, x_wdata, mod_start, mod_end, x_rdata, x_next_addr;
   logic [14:0] psv_addr;
   logic y_req, multiply_accumulate_class, y_modulo, y_rvalid;
   logic [15:0] y_addr, y_rdata, y_next_addr, sfr_wdata, sfr_rdata, a;
   logic sfr_wr_lo, sfr_wr_hi, sfr_implemented, wreg_we, wreg_byte, addr_err_req;
   logic [10:0] sfr_addr;
   logic [3:0] wreg_sel;
   logic [15:0] wreg_wdata, wreg_rdata;
   logic [1:0] ext_op, addr_err_kind;
   logic [7:0] mem [4096];
   logic [15:0] wr [16];
   int miscompares, num_checks, seed, r;

   msa_top #(.RAM_END(RAM_END_T), .XY_BOUNDARY(16'h0c00), .RAM_WORDS(2048)) i_msa_top (
      .clk, .rst_n, .pc_advance, .pc_backward, .pc_load, .pc_load_addr, .vector_take, .vector_alt,
      .vector_num, .program_counter, .prog_word, .prog_fetch_word, .x_req, .x_write, .x_byte,
      .x_near, .effective_address, .x_wdata, .x_modulo, .x_bitrev, .mod_start, .mod_end, .x_rdata,
      .x_rvalid, .x_next_addr, .psv_req, .psv_addr, .y_req, .multiply_accumulate_class, .y_addr,
      .y_modulo, .y_rdata, .y_rvalid, .y_next_addr, .sfr_wr_lo, .sfr_wr_hi, .sfr_addr, .sfr_wdata,
      .sfr_rdata, .sfr_implemented, .wreg_we, .wreg_byte, .wreg_sel, .wreg_wdata, .ext_op,
      .wreg_rdata, .addr_err_req, .addr_err_kind);
   msa_sfr_model #(.IMPL(IMPL)) i_msa_sfr_model (.clk, .rst_n, .effective_address, .sfr_wr_lo,
      .sfr_wr_hi, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_implemented);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(string n, logic [23:0] s, logic [23:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   // unmapped, beyond the ram and the visibility half all read as zero
   function automatic logic [15:0] exp_read(logic [15:0] ea, logic b);
      logic [15:0] wd;
      wd = 16'h0000;
      if (!ea[15] && ea < RAM_END_T && (ea >= 16'h0800 || ea < IMPL))
         wd = {mem[{ea[11:1], 1'b1}], mem[{ea[11:1], 1'b0}]};
      if (b) return ea[0] ? {8'h00, wd[15:8]} : {8'h00, wd[7:0]};
      return wd;
   endfunction : exp_read

   task automatic pcs(logic adv, logic bk, logic ld, logic vt, logic va, logic [23:0] la, logic [6:0] vn);
      logic [23:0] f;
      @(posedge clk);
      #1;
      {pc_advance, pc_backward, pc_load, vector_take, vector_alt} = {adv, bk, ld, vt, va};
      pc_load_addr = la;
      vector_num = vn;
      r = $random(seed);
      f = r[23:0];
      prog_fetch_word = f;
      @(posedge clk);
      #1;
      {pc_advance, pc_backward, pc_load, vector_take} = 4'h0;
      chk("program_counter", program_counter, pc);
      chk("prog_word", prog_word, f);
   endtask : pcs

   task automatic xacc(logic w, logic b, logic n, logic [15:0] ad, logic [15:0] d);
      logic [15:0] ea, nx;
      logic mis, lo, hi;
      @(posedge clk);
      #1;
      {x_req, x_write, x_byte, x_near, effective_address, x_wdata} = {1'b1, w, b, n, ad, d};
      ea = n ? {3'h0, ad[12:0]} : ad;
      mis = !b && ea[0];
      nx = ad + (b ? 16'h0001 : 16'h0002);
      if (x_modulo && nx > mod_end) nx = mod_start;
      if (w && x_bitrev) nx = ad ^ mod_end;
      lo = w && !mis && ea < 16'h0800 && (!b || !ea[0]);
      hi = w && !mis && ea < 16'h0800 && (!b || ea[0]);
      @(posedge clk);
      #1;
      x_req = 1'b0;
      chk("x_rvalid", x_rvalid, !w);
      chk("addr_err_req", addr_err_req, mis);
      chk("addr_err_kind", addr_err_kind, mis ? (w ? 2 : 1) : 0);
      if (!w && !mis) chk("x_rdata", x_rdata, exp_read(ea, b));
      chk("x_next_addr", x_next_addr, nx);
      chk("sfr_wr_lo", sfr_wr_lo, lo);
      chk("sfr_wr_hi", sfr_wr_hi, hi);
      if (lo || hi) chk("sfr_addr", sfr_addr, ea[10:0]);
      if (lo || hi) chk("sfr_wdata", b ? (ea[0] ? sfr_wdata[15:8] : sfr_wdata[7:0]) : sfr_wdata, b ? d[7:0] : d);
      chk("psv_req", psv_req, !w && ea[15]);
      if (!w && ea[15]) chk("psv_addr", psv_addr, ea[14:0]);
      if (w && !mis && ea < RAM_END_T && (ea >= 16'h0800 || ea < IMPL)) begin
         if (!b || !ea[0]) mem[{ea[11:1], 1'b0}] = d[7:0];
         if (!b || ea[0]) mem[{ea[11:1], 1'b1}] = b ? d[7:0] : d[15:8];
      end
   endtask : xacc

   task automatic yrd(logic m, logic [15:0] ad);
      logic [15:0] nx;
      @(posedge clk);
      #1;
      {y_req, multiply_accumulate_class, y_addr} = {1'b1, m, ad};
      nx = ad + 16'h0002;
      if (y_modulo && nx > mod_end) nx = mod_start;
      @(posedge clk);
      #1;
      y_req = 1'b0;
      chk("y_rvalid", y_rvalid, m);
      if (m) chk("y_rdata", y_rdata, exp_read(ad, 1'b0));
      if (m) chk("y_next_addr", y_next_addr, nx);
   endtask : yrd

   task automatic wrg(logic b, logic [3:0] s, logic [15:0] d, logic [1:0] e);
      logic [15:0] x;
      @(posedge clk);
      #1;
      {wreg_we, wreg_byte, wreg_sel, wreg_wdata, ext_op} = {1'b1, b, s, d, e};
      x = e == 2'h1 ? {{8{d[7]}}, d[7:0]} : e == 2'h2 ? {8'h00, d[7:0]} : b ? {wr[s][15:8], d[7:0]} : d;
      @(posedge clk);
      #1;
      wreg_we = 1'b0;
      ext_op = 2'h0;
      chk("wreg_rdata", wreg_rdata, x);
      wr[s] = x;
   endtask : wrg

   initial begin
      #1000000;
      miscompares++;
      print_verdict();
   end

   initial begin
      seed = 32'h8687;
      {rst_n, pc_advance, pc_backward, pc_load, vector_take, vector_alt, vector_num} = 0;
      {pc_load_addr, prog_fetch_word, x_req, x_write, x_byte, x_near, x_modulo, x_bitrev} = 0;
      {effective_address, x_wdata, mod_start, mod_end, y_req, multiply_accumulate_class} = 0;
      {y_addr, y_modulo, wreg_we, wreg_byte, wreg_sel, wreg_wdata, ext_op} = 0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      pc = 24'h00_0000;
      chk("program_counter", program_counter, msa_pkg::RESET_VECTOR_ADDR);
      repeat (3) begin
         pc = pc + msa_pkg::PC_STEP;
         pcs(1, 0, 0, 0, 0, 24'h00_0000, 7'h00);
      end
      pc = pc - msa_pkg::PC_STEP;
      pcs(1, 1, 0, 0, 0, 24'h00_0000, 7'h00);
      pc = 24'h00_1234;
      pcs(0, 0, 1, 0, 0, 24'h00_1234, 7'h00);
      pc = msa_pkg::PRIMARY_TABLE_BASE + 24'h00_000a;
      pcs(1, 0, 1, 1, 0, 24'h00_4000, 7'h05);
      pc = msa_pkg::ALTERNATE_TABLE_BASE + 24'h00_000a;
      pcs(0, 0, 0, 1, 1, 24'h00_0000, 7'h05);
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk("program_counter", program_counter, msa_pkg::RESET_VECTOR_ADDR);
      $display("test program counter done");
      for (int i = 0; i < 4096; i += 2) begin
         r = $random(seed);
         if (i < 64 || i >= 2048) xacc(1, 0, 0, i[15:0], r[15:0]);
      end
      xacc(0, 0, 0, 16'h0901, 16'h0000);
      xacc(1, 0, 0, 16'h0903, 16'hbeef);
      xacc(0, 0, 0, 16'h0902, 16'h0000);
      xacc(0, 0, 1, 16'he900, 16'h0000);
      xacc(0, 0, 0, 16'h8123, 16'h0000);
      xacc(0, 1, 0, 16'h2001, 16'h0000);
      xacc(0, 0, 0, 16'h0200, 16'h0000);
      xacc(1, 1, 0, 16'h0a01, 16'h33a5);
      xacc(0, 0, 0, 16'h0a00, 16'h0000);
      {x_modulo, mod_start, mod_end} = {1'b1, 16'h0880, 16'h0901};
      xacc(0, 0, 0, 16'h0900, 16'h0000);
      x_modulo = 1'b0;
      {x_bitrev, mod_end} = {1'b1, 16'h0010};
      xacc(1, 0, 0, 16'h0a00, 16'h1234);
      xacc(0, 0, 0, 16'h0a00, 16'h0000);
      x_bitrev = 1'b0;
      $display("test x corners done");
      repeat (500) begin
         r = $random(seed);
         case (r[17:16])
            2'h0: a = {9'h000, r[6:0]};
            2'h3: a = r[15:0];
            default: a = 16'h0800 | {5'h00, r[10:0]};
         endcase
         xacc(r[19], r[18], 0, a, r[31:16]);
      end
      $display("test x random done");
      repeat (20) begin
         r = $random(seed);
         yrd(r[0], {6'h03, r[9:1], 1'b0});
      end
      {y_modulo, mod_start, mod_end} = {1'b1, 16'h0c00, 16'h0c05};
      yrd(1, 16'h0c04);
      y_modulo = 1'b0;
      $display("test y done");
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         wrg(0, i[3:0], r[15:0], 2'h0);
      end
      repeat (60) begin
         r = $random(seed);
         wrg(r[4], r[3:0], r[31:16], 2'h0);
      end
      for (int i = 0; i < 4; i++) wrg(0, i[3:0], wr[i], i[0] ? 2'h1 : 2'h2);
      $display("test working registers done");
      print_verdict();
   end
endmodule : memory_space_access_unit_test
